// File: rtl/slave_port.sv
// Purpose: Slave port giving an outside master register and shared memory access
// Assumes: Pins are asynchronous to mclk; register file answers reads combinationally
// Notes: No bus of its own; latencies count from the synchronised sample
`timescale 1ns/1ps
module slave_port
  import slave_port_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic reg_select_n,
  input wire logic shared_mem_request_n,
  input wire logic slave_addr_strobe,
  input wire logic slave_write_read,
  input wire logic bus_mode_select,
  input wire logic [ADDR_W-1:0] reg_addr_pin,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic slave_mem_ack_n,
  output logic slave_ready_out_n,
  output logic [1:0] size_ack_pair_n,
  output logic size_ack_oe,
  input wire logic core_busy,
  output logic [ADDR_W-1:0] reg_addr,
  output logic reg_rd_pulse,
  output logic reg_wr_pulse,
  output logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata
);
  logic [PIN_W-1:0] pins_s;
  logic sel_s;
  logic shared_mem_request_n_s;
  logic mode_s;
  logic strobe_act;
  logic [DATA_W-1:0] data_s;
  port_state_t state_r;
  port_state_t state_nxt;
  logic first_r;
  logic first_nxt;
  logic mode_r;
  logic read_r;
  logic [ADDR_W-1:0] addr_r;
  logic ack_n_r;
  logic ready_n_r;
  logic [1:0] size_ack_r;
  logic size_oe_r;
  logic [DATA_W-1:0] dout_r;
  logic doe_r;
  logic rd_r;
  logic wr_r;
  logic [DATA_W-1:0] wdata_r;
  logic ack_go;
  latency_if lat ();

  // Active-low pins are inverted first so every synced line resets inactive
  pin_sync #(.W(PIN_W)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d({bus_mode_select, slave_write_read, slave_addr_strobe, ~shared_mem_request_n,
        ~reg_select_n, reg_addr_pin, data_in}),
    .q(pins_s)
  );

  ack_timer u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .lat(lat)
  );

  // Decoded synchronised lines
  assign sel_s = pins_s[PIN_SEL];
  assign shared_mem_request_n_s = pins_s[PIN_SHARED_MEM_REQUEST_N];
  assign mode_s = pins_s[PIN_MODE];
  assign data_s = pins_s[DATA_W-1:0];
  assign strobe_act = mode_s ? ~pins_s[PIN_STB] : pins_s[PIN_STB];

  // Control sequence; from idle, select wins if the master breaks the exclusion
  always_comb begin
    state_nxt = state_r;
    first_nxt = first_r;
    lat.start = 1'b0;
    lat.cycles = core_busy ? REG_LAT_BUSY : REG_LAT_IDLE;
    unique case (state_r)
      ST_IDLE: begin
        if (sel_s) begin
          if (strobe_act) begin
            state_nxt = ST_REG_LAT;
            lat.start = 1'b1;
          end else begin
            state_nxt = ST_REG_WAIT;
            first_nxt = 1'b1;
          end
        end else if (shared_mem_request_n_s) begin
          state_nxt = ST_MEM_LAT;
          lat.start = 1'b1;
          lat.cycles = core_busy ? MEM_LAT_BUSY : MEM_LAT_IDLE;
        end
      end
      ST_MEM_LAT: begin
        if (!shared_mem_request_n_s) state_nxt = ST_IDLE;
        else if (lat.done) state_nxt = ST_MEM_ACK;
      end
      ST_MEM_ACK: begin
        if (!shared_mem_request_n_s) state_nxt = ST_IDLE;
      end
      ST_REG_WAIT: begin
        if (!sel_s) begin
          state_nxt = ST_IDLE;
        end else if (strobe_act && first_r) begin
          state_nxt = ST_REG_HOLD;
        end else if (strobe_act) begin
          state_nxt = ST_REG_LAT;
          lat.start = 1'b1;
        end
      end
      ST_REG_LAT: begin
        if (!sel_s) state_nxt = ST_IDLE;
        else if (!strobe_act) state_nxt = ST_REG_WAIT;
        else if (lat.done) state_nxt = ST_REG_ACK;
      end
      ST_REG_ACK: begin
        if (!sel_s) begin
          state_nxt = ST_REG_END;
        end else if (!strobe_act) begin
          state_nxt = ST_REG_WAIT;
          first_nxt = 1'b0;
        end
      end
      ST_REG_HOLD: begin
        if (!sel_s) begin
          state_nxt = ST_IDLE;
        end else if (!strobe_act) begin
          state_nxt = ST_REG_WAIT;
          first_nxt = 1'b0;
        end
      end
      ST_REG_END: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State and first-strobe flag
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      first_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      first_r <= first_nxt;
    end
  end

  // Mode is frozen for the whole access so the completion pins never swap mid-cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) mode_r <= 1'b0;
    else if (state_r == ST_IDLE) mode_r <= mode_s;
  end

  // Address and direction follow the pins while the strobe pin is low and freeze on its rise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      addr_r <= '0;
      read_r <= 1'b0;
    end else if (!pins_s[PIN_STB]) begin
      addr_r <= pins_s[PIN_ADDR +: ADDR_W];
      read_r <= pins_s[PIN_DIR];
    end
  end

  assign ack_go = (state_nxt == ST_REG_ACK) && (state_r != ST_REG_ACK);

  // Acknowledge and completion strobes; all but the pair enable drop when the next state leaves the ack state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack_n_r <= 1'b1;
      ready_n_r <= 1'b1;
      size_ack_r <= SIZE_ACK_OFF;
      size_oe_r <= 1'b0;
    end else begin
      ack_n_r <= !(state_nxt == ST_MEM_ACK || state_nxt == ST_REG_ACK);
      ready_n_r <= !(state_nxt == ST_REG_ACK && !mode_r);
      size_ack_r <= (state_nxt == ST_REG_ACK) ? SIZE_ACK_ON : SIZE_ACK_OFF;
      // Select end drives the pair high one cycle; only the strobe end releases at once
      size_oe_r <= mode_r && (state_nxt == ST_REG_ACK || state_nxt == ST_REG_END);
    end
  end

  // Read data is taken from the register file the edge the access completes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dout_r <= '0;
      doe_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      rd_r <= ack_go && read_r;
      doe_r <= (state_nxt == ST_REG_ACK) && read_r;
      if (ack_go && read_r) dout_r <= reg_rdata;
    end
  end

  // Write data comes from the clocked data sample, not the strobe edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_r <= 1'b0;
      wdata_r <= '0;
    end else begin
      wr_r <= ack_go && !read_r;
      if (ack_go && !read_r) wdata_r <= data_s;
    end
  end

  assign slave_mem_ack_n = ack_n_r;
  assign slave_ready_out_n = ready_n_r;
  assign size_ack_pair_n = size_ack_r;
  assign size_ack_oe = size_oe_r;
  assign data_out = dout_r;
  assign data_oe = doe_r;
  assign reg_addr = addr_r;
  assign reg_rd_pulse = rd_r;
  assign reg_wr_pulse = wr_r;
  assign reg_wdata = wdata_r;

  property p_mem_lat;
    @(posedge mclk) disable iff (!rstn)
      (state_r == ST_IDLE && shared_mem_request_n_s && !sel_s) |-> ##[1:8] (!ack_n_r || !shared_mem_request_n_s);
  endproperty
  a_mem_lat: assert property (p_mem_lat) else $error("memory ack too late");

  property p_mem_hold;
    @(posedge mclk) disable iff (!rstn)
      (state_r == ST_MEM_ACK && shared_mem_request_n_s) |=> !ack_n_r;
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory ack dropped");

  property p_mem_release;
    @(posedge mclk) disable iff (!rstn)
      (state_r == ST_MEM_ACK && !shared_mem_request_n_s) |=> ack_n_r;
  endproperty
  a_mem_release: assert property (p_mem_release) else $error("memory ack held");

  property p_reg_needs_strobe;
    @(posedge mclk) disable iff (!rstn)
      ($fell(ack_n_r) && state_r == ST_REG_ACK) |-> $past(strobe_act) && $past(sel_s);
  endproperty
  a_reg_needs_strobe: assert property (p_reg_needs_strobe) else $error("ack w/o strobe");

  property p_late_strobe;
    @(posedge mclk) disable iff (!rstn)
      (state_r == ST_REG_HOLD) |-> ack_n_r && ready_n_r && !doe_r;
  endproperty
  a_late_strobe: assert property (p_late_strobe) else $error("late strobe acked");

  property p_ready_pair;
    @(posedge mclk) disable iff (!rstn)
      !ready_n_r |-> !ack_n_r && !mode_r && !size_oe_r;
  endproperty
  a_ready_pair: assert property (p_ready_pair) else $error("ready outside ack");

  property p_size_ack;
    @(posedge mclk) disable iff (!rstn)
      (size_ack_r == SIZE_ACK_ON) && size_oe_r |-> mode_r && ready_n_r;
  endproperty
  a_size_ack: assert property (p_size_ack) else $error("size ack in mode 0");

  property p_sel_end;
    @(posedge mclk) disable iff (!rstn)
      (state_r == ST_REG_ACK && !sel_s) |=> ack_n_r && ready_n_r && !doe_r;
  endproperty
  a_sel_end: assert property (p_sel_end) else $error("select end ignored");

  property p_wr_pulse;
    @(posedge mclk) disable iff (!rstn)
      wr_r |-> !read_r ##1 !wr_r;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse wrong");

  // Read data may only be driven while the access is acknowledged
  property p_read_drive;
    @(posedge mclk) disable iff (!rstn)
      doe_r |-> state_r == ST_REG_ACK && !ack_n_r;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data outside ack");

  // One read pulse per access, always alongside the driven data
  property p_rd_pulse;
    @(posedge mclk) disable iff (!rstn)
      rd_r |-> doe_r && !wr_r ##1 !rd_r;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse wrong");
endmodule : slave_port

// File: rtl/slave_port_pkg.sv
// Purpose: Shared constants and types for the slave register and shared memory port
// Assumes: One bus clock, mclk, at 100 MHz
// Notes: Latency figures are in bus clock cycles
package slave_port_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  // Sampled pin bundle: mode, direction, strobe, mem request, select, address, data
  localparam int PIN_W = 5 + ADDR_W + DATA_W;
  localparam int PIN_MODE = PIN_W - 1;
  localparam int PIN_DIR = PIN_W - 2;
  localparam int PIN_STB = PIN_W - 3;
  localparam int PIN_SHARED_MEM_REQUEST_N = PIN_W - 4;
  localparam int PIN_SEL = PIN_W - 5;
  localparam int PIN_ADDR = DATA_W;
  localparam logic [PIN_W-1:0] PIN_RST = '0;
  // Extra wait cycles before acknowledge, idle versus busy controller
  localparam logic [2:0] MEM_LAT_IDLE = 3'h1;
  localparam logic [2:0] MEM_LAT_BUSY = 3'h5;
  localparam logic [2:0] REG_LAT_IDLE = 3'h0;
  localparam logic [2:0] REG_LAT_BUSY = 3'h4;
  localparam logic [1:0] SIZE_ACK_ON = 2'h0;
  localparam logic [1:0] SIZE_ACK_OFF = 2'h3;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_MEM_LAT = 8'h02,
    ST_MEM_ACK = 8'h04,
    ST_REG_WAIT = 8'h08,
    ST_REG_LAT = 8'h10,
    ST_REG_ACK = 8'h20,
    ST_REG_HOLD = 8'h40,
    ST_REG_END = 8'h80
  } port_state_t;
endpackage : slave_port_pkg

// File: rtl/latency_if.sv
// Purpose: Carries a latency request from the port controller to its timer
// Assumes: Same clock on both sides
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
interface latency_if;
  logic start;
  logic [2:0] cycles;
  logic done;
  modport ctl (output start, output cycles, input done);
  modport tmr (input start, input cycles, output done);
endinterface : latency_if

// File: rtl/pin_sync.sv
// Purpose: Two-stage capture of asynchronous pins onto the bus clock
// Assumes: Select and request arrive active high; the strobe polarity follows the bus mode
// Notes: First stage on the falling edge, second on the rising edge
`timescale 1ns/1ps
module pin_sync
  import slave_port_pkg::*;
#(
  parameter int W = PIN_W
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  genvar i;
  // Falling edge catch then rising edge settle; the first stage feeds only the second
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(negedge mclk or negedge rstn) begin
        if (!rstn) meta_r[i] <= PIN_RST[i];
        else meta_r[i] <= d[i];
      end
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) q[i] <= PIN_RST[i];
        else q[i] <= meta_r[i];
      end
    end
  endgenerate
endmodule : pin_sync

// File: rtl/ack_timer.sv
// Purpose: Counts the wait cycles before the acknowledge is given
// Assumes: A new start reloads the count at once
// Notes: done fires once per start, after cycles+1 edges
`timescale 1ns/1ps
module ack_timer
  import slave_port_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  latency_if.tmr lat
);
  logic [2:0] cnt_r;
  logic run_r;
  assign lat.done = run_r && (cnt_r == 3'h0);
  // Load on start, count down, stop at zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 3'h0;
      run_r <= 1'b0;
    end else if (lat.start) begin
      cnt_r <= lat.cycles;
      run_r <= 1'b1;
    end else if (lat.done) begin
      run_r <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
  property p_done_bound;
    @(posedge mclk) disable iff (!rstn)
      lat.start |-> ##[1:6] (lat.done || lat.start);
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("timer done late");
endmodule : ack_timer

// File: test/host_master_model.sv
// Purpose: Behavioural outside master that drives the slave port pins
// Assumes: Callers enter each task just after a rising edge of mclk
// Notes: Released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module host_master_model
  import slave_port_pkg::*;
(
  input wire logic mclk,
  output logic reg_select_n,
  output logic shared_mem_request_n,
  output logic slave_addr_strobe,
  output logic slave_write_read,
  output logic bus_mode_select,
  output logic [ADDR_W-1:0] reg_addr_pin,
  output logic [DATA_W-1:0] data_in
);
  logic stb_on;
  // Strobe pin level follows the polarity chosen by the bus mode
  assign slave_addr_strobe = bus_mode_select ? ~stb_on : stb_on;
  // Idle pins at time zero
  initial begin
    reg_select_n = 1'b1;
    shared_mem_request_n = 1'b1;
    bus_mode_select = 1'b0;
    stb_on = 1'b0;
    slave_write_read = 1'b1;
    reg_addr_pin = 6'h00;
    data_in = 16'h0000;
  end
  // Pins move 1 ns after the edge, so no change races the sampling edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic set_mode(input logic m); bus_mode_select = m; endtask : set_mode
  task automatic set_sel(input logic on); reg_select_n = ~on; endtask : set_sel
  task automatic set_mem(input logic on); shared_mem_request_n = ~on; endtask : set_mem
  task automatic set_stb(input logic on); stb_on = on; endtask : set_stb
  task automatic set_data(input logic [DATA_W-1:0] d); data_in = d; endtask : set_data
  // Address and direction settle a full clock before the strobe moves
  task automatic setup(input logic [ADDR_W-1:0] a, input logic rd, input logic [DATA_W-1:0] d);
    reg_addr_pin = a;
    slave_write_read = rd;
    data_in = d;
  endtask : setup
  // Released lines must not keep showing the old value
  task automatic release_lines();
    reg_addr_pin = ~reg_addr_pin;
    data_in = ~data_in;
  endtask : release_lines
endmodule : host_master_model

// File: test/slave_register_and_shared_memory_access_bench.sv
// Purpose: Self-checking bench for the slave register and shared memory port
// Assumes: Latencies are counted in rising edges after a pin change
// Notes: Register file stand-in returns a value derived from the address
`timescale 1ns/1ps
module slave_register_and_shared_memory_access_bench
  import slave_port_pkg::*;
;
  logic mclk, rstn, core_busy;
  logic reg_select_n, shared_mem_request_n, slave_addr_strobe, slave_write_read;
  logic bus_mode_select, data_oe, slave_mem_ack_n, slave_ready_out_n, size_ack_oe;
  logic reg_rd_pulse, reg_wr_pulse;
  logic [1:0] size_ack_pair_n;
  logic [ADDR_W-1:0] reg_addr_pin, reg_addr;
  logic [DATA_W-1:0] data_in, data_out, reg_wdata, reg_rdata;
  int bad_count = 0;
  int comparisons = 0;
  // 100 MHz bus clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  host_master_model mst (
    .mclk(mclk),
    .reg_select_n(reg_select_n),
    .shared_mem_request_n(shared_mem_request_n),
    .slave_addr_strobe(slave_addr_strobe),
    .slave_write_read(slave_write_read),
    .bus_mode_select(bus_mode_select),
    .reg_addr_pin(reg_addr_pin),
    .data_in(data_in)
  );
  slave_port DUT (
    .mclk(mclk),
    .rstn(rstn),
    .reg_select_n(reg_select_n),
    .shared_mem_request_n(shared_mem_request_n),
    .slave_addr_strobe(slave_addr_strobe),
    .slave_write_read(slave_write_read),
    .bus_mode_select(bus_mode_select),
    .reg_addr_pin(reg_addr_pin),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .slave_mem_ack_n(slave_mem_ack_n),
    .slave_ready_out_n(slave_ready_out_n),
    .size_ack_pair_n(size_ack_pair_n),
    .size_ack_oe(size_ack_oe),
    .core_busy(core_busy),
    .reg_addr(reg_addr),
    .reg_rd_pulse(reg_rd_pulse),
    .reg_wr_pulse(reg_wr_pulse),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );
  // Register file stand-in, combinational from the latched address; every bit tracks it
  assign reg_rdata = {reg_addr, ~reg_addr, reg_addr[5:2]};
  function automatic logic [DATA_W-1:0] rfile(input logic [ADDR_W-1:0] a);
    return {a, ~a, a[5:2]};
  endfunction : rfile
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait, so a missing acknowledge still ends with a mismatch
  task automatic wait_ack(input int exp_n);
    int n;
    n = 0;
    while (slave_mem_ack_n !== 1'b0 && n < 12) begin
      mst.step(1);
      n++;
    end
    chk(16'(n), 16'(exp_n));
  endtask : wait_ack
  task automatic t_mem(input logic busy);
    core_busy = busy;
    mst.set_mem(1'b1);
    wait_ack(busy ? 8 : 4);
    repeat (6) begin
      mst.step(1);
      chk(16'({slave_mem_ack_n, slave_ready_out_n, data_oe}), 16'h2);
    end
    mst.set_mem(1'b0);
    mst.step(1);
    chk(16'(slave_mem_ack_n), 16'h0);
    mst.step(1);
    chk(16'(slave_mem_ack_n), 16'h1);
    core_busy = 1'b0;
    mst.step(2);
  endtask : t_mem
  // how: 0 strobe ends then select drops, 1 select held for the next, 2 select ends it
  task automatic t_reg(input logic mode, rd, busy, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] wd, input int how);
    mst.set_mode(mode);
    core_busy = busy;
    mst.setup(a, rd, ~wd);
    mst.step(1);
    mst.set_sel(1'b1);
    mst.set_stb(1'b1);
    mst.set_data(wd);
    wait_ack(busy ? 7 : 3);
    chk(16'(slave_ready_out_n), 16'(mode));
    chk(16'({size_ack_oe, size_ack_pair_n}), mode ? 16'h4 : 16'h0);
    chk(16'(data_oe), 16'(rd));
    chk(rd ? data_out : reg_wdata, rd ? rfile(a) : wd);
    chk(16'({reg_rd_pulse, reg_wr_pulse}), rd ? 16'h2 : 16'h1);
    chk(16'(reg_addr), 16'(a));
    mst.step(1);
    chk(16'({slave_mem_ack_n, reg_rd_pulse, reg_wr_pulse}), 16'h0);
    if (how == 2) mst.set_sel(1'b0);
    else mst.set_stb(1'b0);
    mst.step(1);
    chk(16'(slave_mem_ack_n), 16'h0);
    mst.step(1);
    chk(16'({slave_mem_ack_n, slave_ready_out_n, data_oe}), 16'h6);
    chk(16'(size_ack_pair_n), 16'h3);
    if (how == 2 && mode) begin
      chk(16'(size_ack_oe), 16'h1);
      mst.step(1);
      chk(16'(size_ack_oe), 16'h0);
    end
    mst.set_stb(1'b0);
    if (how != 1) mst.set_sel(1'b0);
    // Release now, so the next call never rewrites a pin in the same time step
    mst.release_lines();
    core_busy = 1'b0;
    mst.step(2);
  endtask : t_reg
  // Strobe first seen after select: no answer until it ends, the next one is answered
  task automatic t_late(input logic mode);
    mst.set_mode(mode);
    mst.setup(6'h0c, 1'b1, 16'h0000);
    mst.step(1);
    mst.set_sel(1'b1);
    mst.step(3);
    mst.set_stb(1'b1);
    repeat (8) begin
      mst.step(1);
      chk(16'(slave_mem_ack_n), 16'h1);
    end
    mst.set_stb(1'b0);
    mst.step(2);
    t_reg(mode, 1'b1, 1'b0, 6'h0c, 16'h0000, 0);
  endtask : t_late
  // Strobe withdrawn before the long latency runs out: no acknowledge at all
  task automatic t_abort();
    core_busy = 1'b1;
    mst.set_mode(1'b0);
    mst.setup(6'h07, 1'b1, 16'h0000);
    mst.step(1);
    mst.set_sel(1'b1);
    mst.set_stb(1'b1);
    mst.step(2);
    mst.set_stb(1'b0);
    repeat (8) begin
      mst.step(1);
      chk(16'({slave_mem_ack_n, data_oe}), 16'h2);
    end
    mst.set_sel(1'b0);
    core_busy = 1'b0;
    mst.step(2);
  endtask : t_abort
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // The sequence needs well under 1000 clocks; 2000 leaves room for slow answers
  initial begin
    #20000;
    bad_count++;
    end_of_test();
  end
  initial begin
    rstn = 1'b0;
    core_busy = 1'b0;
    repeat (4) @(posedge mclk);
    #1 rstn = 1'b1;
    mst.step(1);
    chk(16'({slave_mem_ack_n, slave_ready_out_n, size_ack_pair_n, size_ack_oe, data_oe,
      reg_rd_pulse, reg_wr_pulse}), 16'hf0);
    t_mem(1'b0);
    t_mem(1'b1);
    t_reg(1'b0, 1'b1, 1'b0, 6'h15, 16'h0000, 0);
    t_reg(1'b0, 1'b0, 1'b0, 6'h2a, 16'hbeef, 0);
    t_reg(1'b0, 1'b1, 1'b1, 6'h3f, 16'h0000, 1);
    t_reg(1'b0, 1'b0, 1'b0, 6'h01, 16'h1234, 0);
    t_reg(1'b1, 1'b1, 1'b0, 6'h22, 16'h0000, 0);
    t_reg(1'b1, 1'b0, 1'b1, 6'h30, 16'ha5c3, 0);
    t_reg(1'b1, 1'b1, 1'b0, 6'h0f, 16'h0000, 2);
    t_reg(1'b0, 1'b0, 1'b0, 6'h3c, 16'h5a5a, 2);
    t_late(1'b0);
    t_late(1'b1);
    t_abort();
    end_of_test();
  end
endmodule : slave_register_and_shared_memory_access_bench
